/* graphics_power_mgmt_capability.sv */
// Power-management capability registers and above-4GB host access sink
//
// Summary of operation
// - Header low byte always reads capability identifier 01h; writes ignored.
// - Header high byte, next list pointer, always reads 00h.
// - Capability word bits 2:0 hardwired to version 010b.
// - Capability word bit 5 reads 1: device-specific initialization needed.
// - Capability word bits 15:11, 4, 3 read 0; no wake signal ever.
// - Capability word bits 10, 9 and 8:6 read 0.
// - Control/status bit 15, wake status flag, always reads 0.
// - Control/status bit 8, wake enable, writable, resets to 0.
// - Control/status bits 14:9 and 7:2 read zero; writes ignored.
// - Bits 1:0 hold sleep level; 00 D0, 01 D1, 10 D2, 11 D3.
// - Writes of 01 or 10 complete normally but leave the level unchanged.
// - Processor memory accesses at or above 4 GB are claimed, not forwarded.
// - Claimed writes drop data; claimed reads return all zeros.
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/10ps
module graphics_power_mgmt_capability #(
   parameter int data_w = 32,
   parameter int addr_w = 6,
   parameter int host_addr_w = pm_capability_word_pkg::host_addr_w,
   parameter int cs_w = pm_capability_word_pkg::cs_w
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire pm_capability_word_pkg::host_req_t host_req,
   output pm_capability_word_pkg::host_rsp_t host_rsp,
   output logic wake_out,
   output logic [1:0] sleep_level
);

   // Handshake states; every taken request gets exactly one answer cycle
   typedef enum logic [0:0] {
      bus_idle = 1'b0,
      bus_answer = 1'b1
   } bus_state_t;

   // Bits software may change in the control/status half-word
   localparam logic [15:0] level_mask = 16'h0003;
   localparam logic [15:0] wake_mask = 16'h0001 << pm_capability_word_pkg::wake_enable_pos;
   localparam logic [15:0] cs_writable = level_mask | wake_mask;

   // Decode and flop widths are built for these sizes only
   if (data_w != 32) begin : g_bad_data_w
      $error("data_w must be 32");
   end

   if (addr_w != 6) begin : g_bad_addr_w
      $error("addr_w must be 6");
   end

   if (host_addr_w != pm_capability_word_pkg::host_addr_w) begin : g_bad_host_w
      $error("host_addr_w must be 36");
   end

   if (cs_w != pm_capability_word_pkg::cs_w) begin : g_bad_cs_w
      $error("cs_w must be 16");
   end

   // The word map must agree with the byte offsets
   if ({pm_capability_word_pkg::word_dc, 2'b00} != pm_capability_word_pkg::pm_capability_header_off) begin : g_hdr_map
      $error("header word address does not match its offset");
   end

   if ({pm_capability_word_pkg::word_dc, 2'b10} != pm_capability_word_pkg::pm_capability_word_off) begin : g_cap_map
      $error("capability word address does not match its offset");
   end

   if ({pm_capability_word_pkg::word_e0, 2'b00} != pm_capability_word_pkg::pm_control_status_off) begin : g_cs_map
      $error("control word address does not match its offset");
   end

   // Fixed fields and reset values must tell the same story
   if (pm_capability_word_pkg::pm_capability_header_rst != {pm_capability_word_pkg::next_list_pointer,
         pm_capability_word_pkg::capability_identifier}) begin : g_hdr_rst
      $error("header reset value disagrees with its fields");
   end

   if (pm_capability_word_pkg::pm_control_status_rst[1:0] != pm_capability_word_pkg::sleep_level_rst) begin : g_lvl_rst
      $error("level reset value disagrees with the control reset");
   end

   // The wake status flag must never become writable
   if (cs_writable[pm_capability_word_pkg::wake_status_pos]) begin : g_wake_sts
      $error("wake status bit marked writable");
   end

   // Word match, shared by read and write decode
   function automatic logic word_hit(
      input logic [5:0] addr,
      input logic [5:0] word
   );
      return addr == word;
   endfunction : word_hit

   // The level field takes D0 and D3 only
   function automatic logic level_supported(
      input logic [1:0] code
   );
      logic ok;
      ok = 1'b0;
      if (code == pm_capability_word_pkg::level_d0) begin
         ok = 1'b1;
      end
      if (code == pm_capability_word_pkg::level_d3) begin
         ok = 1'b1;
      end
      return ok;
   endfunction : level_supported

   // Spread one byte-lane enable over its eight bits of the half-word
   function automatic logic [15:0] lane_bits(
      input logic on,
      input int lane
   );
      logic [15:0] bits;
      bits = 16'h0000;
      bits[lane * 8 +: 8] = {8{on}};
      return bits;
   endfunction : lane_bits

   // Read view of one word address; unmapped words read as zero
   function automatic logic [31:0] read_view(
      input logic [5:0] addr,
      input logic [15:0] cs
   );
      logic [31:0] view;
      view = 32'h0000_0000;
      if (word_hit(addr, pm_capability_word_pkg::word_dc)) begin
         view[7:0] = pm_capability_word_pkg::capability_identifier;
         view[15:8] = pm_capability_word_pkg::next_list_pointer;
         view[31:16] = pm_capability_word_pkg::pm_capability_word_rst;
      end
      if (word_hit(addr, pm_capability_word_pkg::word_e0)) begin
         view[15:0] = cs;
         view[31:16] = 16'h0000;
      end
      return view;
   endfunction : read_view

   // Handshake
   bus_state_t state_q;
   bus_state_t state_d;
   logic wait_q;
   logic wait_d;

   // Read data, held until the next read answer
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   // Control/status storage, one flop per bit
   logic [15:0] cs_q;
   logic [15:0] cs_d;
   logic [15:0] cs_load;

   // Host sink and wake line
   logic claim_q;
   logic done_q;
   logic [31:0] hdata_q;
   logic wake_q;

   // Request decode
   wire take = (state_q == bus_idle) & (avs_read | avs_write);
   wire take_read = take & avs_read;
   wire take_write = take & avs_write;
   wire write_cs = take_write & word_hit(avs_address, pm_capability_word_pkg::word_e0);
   wire [31:0] read_word = read_view(avs_address, cs_q);

   // Lane enables; a lane left out keeps its bits
   wire level_lane_on = avs_byteenable[pm_capability_word_pkg::level_lane];
   wire wake_lane_on = avs_byteenable[pm_capability_word_pkg::wake_lane];
   wire [15:0] low_lane = lane_bits(write_cs & level_lane_on, pm_capability_word_pkg::level_lane);
   wire [15:0] high_lane = lane_bits(write_cs & wake_lane_on, pm_capability_word_pkg::wake_lane);

   // A refused level still completes on the bus, it just loads nothing into bits 1:0
   wire [1:0] new_level = avs_writedata[1:0];
   wire level_ok = level_supported(new_level);
   wire [15:0] level_gate = level_ok ? 16'hffff : ~level_mask;

   assign cs_load = (low_lane | high_lane) & level_gate & cs_writable;

   // Read-only bits stay zero whatever is written
   for (genvar b = 0; b < 16; b++) begin : g_cs_bit
      if (cs_writable[b]) begin : g_rw
         assign cs_d[b] = cs_load[b] ? avs_writedata[b] : cs_q[b];
      end else begin : g_ro
         assign cs_d[b] = 1'b0;
      end
   end

   // Handshake sequence
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         bus_idle: begin
            if (take) begin
               state_d = bus_answer;
            end
         end
         bus_answer: begin
            state_d = bus_idle;
         end
      endcase
   end

   // Waitrequest is low for the answer cycle only
   assign wait_d = (state_d == bus_answer) ? 1'b0 : 1'b1;
   assign rdata_d = take_read ? read_word : rdata_q;

   // Claim everything at or above 4 GB; nothing goes downstream
   wire host_high = host_req.addr >= pm_capability_word_pkg::four_gb;
   wire host_hit = host_req.valid & host_high;

   // Handshake state
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_q <= bus_idle;
      end else if (clk_en) begin
         state_q <= state_d;
      end
   end

   // Registered so the bus never sees a decode glitch
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wait_q <= 1'b1;
      end else if (clk_en) begin
         wait_q <= wait_d;
      end
   end

   // Read data
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rdata_q <= 32'h0000_0000;
      end else if (clk_en) begin
         rdata_q <= rdata_d;
      end
   end

   // Control/status word; wake enable starts off, level starts at D0
   always_ff @(posedge core_clk) begin
      if (reset) begin
         cs_q <= pm_capability_word_pkg::pm_control_status_rst;
      end else if (clk_en) begin
         cs_q <= cs_d;
      end
   end

   // Claim strobe
   always_ff @(posedge core_clk) begin
      if (reset) begin
         claim_q <= 1'b0;
      end else if (clk_en) begin
         claim_q <= host_hit;
      end
   end

   // Claimed accesses finish the cycle after they are seen
   always_ff @(posedge core_clk) begin
      if (reset) begin
         done_q <= 1'b0;
      end else if (clk_en) begin
         done_q <= host_hit;
      end
   end

   // Writes are dropped and reads see zero, so no data path is kept
   always_ff @(posedge core_clk) begin
      if (reset) begin
         hdata_q <= 32'h0000_0000;
      end else if (clk_en) begin
         hdata_q <= 32'h0000_0000;
      end
   end

   // Wake enable is stored but never produces a wake event
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wake_q <= 1'b0;
      end else if (clk_en) begin
         wake_q <= 1'b0;
      end
   end

   // Bus side
   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;

   // Host, wake and level
   assign host_rsp = {claim_q, done_q, hdata_q};
   assign wake_out = wake_q;
   assign sleep_level = cs_q[1:0];
endmodule : graphics_power_mgmt_capability

/* pm_capability_word_pkg.sv */
// Package for the graphics power-management capability block
package pm_capability_word_pkg;
   // Register byte offsets (16-bit registers, word-aligned access via byte address)
   localparam logic [7:0] pm_capability_header_off = 8'hdc;
   localparam logic [7:0] pm_capability_word_off = 8'hde;
   localparam logic [7:0] pm_control_status_off = 8'he0;
   // Avalon word addresses (byte address / 4)
   localparam logic [5:0] word_dc = 6'h37;
   localparam logic [5:0] word_e0 = 6'h38;
   // Fixed field values
   localparam logic [7:0] capability_identifier = 8'h01;
   localparam logic [7:0] next_list_pointer = 8'h00;
   localparam logic [15:0] pm_capability_header_rst = 16'h0001;
   localparam logic [15:0] pm_capability_word_rst = 16'h0022;
   localparam logic [15:0] pm_control_status_rst = 16'h0000;
   localparam int wake_enable_pos = 8;
   localparam int wake_status_pos = 15;
   localparam int cs_w = 16;
   // Byte lanes of the control/status half-word
   localparam int level_lane = 0;
   localparam int wake_lane = 1;
   // Sleep levels
   typedef enum logic [1:0] {
      level_d0 = 2'b00,
      level_d1 = 2'b01,
      level_d2 = 2'b10,
      level_d3 = 2'b11
   } device_sleep_level_t;
   localparam device_sleep_level_t sleep_level_rst = level_d0;
   // Processor access above 4 GB
   localparam int host_addr_w = 36;
   localparam logic [35:0] four_gb = 36'h1_0000_0000;
   typedef struct packed {
      logic valid;
      logic write;
      logic [35:0] addr;
   } host_req_t;
   typedef struct packed {
      logic claim;
      logic done;
      logic [31:0] rdata;
   } host_rsp_t;
endpackage : pm_capability_word_pkg

/* pm_capability_word_props.sv */
// Port checker for the power-management capability block
`timescale 1ns/10ps
module pm_capability_word_props (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire pm_capability_word_pkg::host_req_t host_req,
   input wire pm_capability_word_pkg::host_rsp_t host_rsp,
   input wire logic wake_out,
   input wire logic [1:0] sleep_level
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   sequence rd_ans(logic [5:0] a);
      !avs_waitrequest && $past(avs_read) && $past(avs_address) == a;
   endsequence
   a_hdr_fixed: assert property (rd_ans(pm_capability_word_pkg::word_dc) |-> avs_readdata == 32'h0022_0001)
      else $error("header word wrong");
   a_cs_zeros: assert property (rd_ans(pm_capability_word_pkg::word_e0) |-> !avs_readdata[31:9] && !avs_readdata[7:2])
      else $error("control zeros wrong");
   a_level_view: assert property (rd_ans(pm_capability_word_pkg::word_e0) |-> avs_readdata[1:0] == sleep_level)
      else $error("level readback wrong");
   a_answer_next: assert property ((avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest)
      else $error("answer late");
   a_wait_pulse: assert property (!avs_waitrequest && clk_en |=> avs_waitrequest)
      else $error("answer too long");
   a_freeze_hold: assert property (!clk_en |=> $stable(sleep_level) && $stable(avs_waitrequest))
      else $error("state moved while frozen");
   a_level_legal: assert property (sleep_level inside {2'h0, 2'h3})
      else $error("unsupported level held");
   a_no_wake: assert property (!wake_out)
      else $error("wake raised");
   a_zero_data: assert property (host_rsp.rdata == 32'h0000_0000)
      else $error("host data not zero");
   a_claim_high: assert property (host_req.valid && clk_en && host_req.addr >= pm_capability_word_pkg::four_gb |=> host_rsp.claim && host_rsp.done)
      else $error("high access not claimed");
   a_claim_low: assert property (host_req.valid && clk_en && host_req.addr < pm_capability_word_pkg::four_gb |=> !host_rsp.claim)
      else $error("low access claimed");
endmodule : pm_capability_word_props

/* graphics_power_mgmt_capability_test.sv */
// Self-checking bench for the power-management capability block
`timescale 1ns/10ps
module graphics_power_mgmt_capability_test;
   logic core_clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, wake_out;
   logic clk_en = 1'b1;
   logic [3:0] be = 4'hf;
   logic [5:0] avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
   logic [1:0] sleep_level;
   logic [15:0] wr [4] = '{16'hffff, 16'h0001, 16'h0002, 16'h0000};
   logic [15:0] ex [4] = '{16'h0103, 16'h0003, 16'h0003, 16'h0000};
   pm_capability_word_pkg::host_req_t host_req = '0;
   pm_capability_word_pkg::host_rsp_t host_rsp;
   int bad_count = 0, checks = 0;
   always #2 core_clk = ~core_clk;
   graphics_power_mgmt_capability graphics_power_mgmt_capability_inst (.core_clk(core_clk),
      .reset(reset), .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .host_req(host_req),
      .host_rsp(host_rsp), .wake_out(wake_out), .sleep_level(sleep_level));
   task give_verdict;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : give_verdict
   task cmp(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("FAIL %0t got %h exp %h", $time, g, e);
      end
   endtask : cmp
   // Idle edge first, so a release never meets a new request in one step
   task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge core_clk);
      {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      {avs_write, avs_read} <= 2'h0;
   endtask : bus
   task t_caps;
      bus(1'b0, pm_capability_word_pkg::word_dc, 0); cmp(q, 32'h0022_0001);
      bus(1'b1, pm_capability_word_pkg::word_dc, 32'hffff_ffff);
      bus(1'b0, pm_capability_word_pkg::word_dc, 0); cmp(q, 32'h0022_0001);
      bus(1'b0, 6'h00, 0); cmp(q, 32'h0000_0000);
      $display("caps done");
   endtask : t_caps
   task t_ctrl;
      bus(1'b0, pm_capability_word_pkg::word_e0, 0); cmp(q, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, pm_capability_word_pkg::word_e0, {16'h0000, wr[i]});
         bus(1'b0, pm_capability_word_pkg::word_e0, 0); cmp(q, {16'h0000, ex[i]});
         cmp({30'h0, sleep_level}, {30'h0, ex[i][1:0]});
      end
      @(posedge core_clk) be <= 4'h2;
      bus(1'b1, pm_capability_word_pkg::word_e0, 32'h0000_ffff);
      @(posedge core_clk) be <= 4'hf;
      bus(1'b0, pm_capability_word_pkg::word_e0, 0); cmp(q, 32'h0000_0100);
      $display("ctrl done");
   endtask : t_ctrl
   task t_freeze;
      @(posedge core_clk) begin
         clk_en <= 1'b0;
         {avs_write, avs_address, avs_writedata} <= {1'b1, pm_capability_word_pkg::word_e0, 32'h0000_0003};
      end
      repeat (4) @(posedge core_clk);
      cmp({31'h0, avs_waitrequest}, 32'h0000_0001);
      cmp({30'h0, sleep_level}, 32'h0000_0000);
      clk_en <= 1'b1;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      cmp({30'h0, sleep_level}, 32'h0000_0003);
      avs_write <= 1'b0;
      $display("freeze done");
   endtask : t_freeze
   task t_reset;
      @(posedge core_clk) reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      cmp({30'h0, sleep_level}, 32'h0000_0000);
      bus(1'b0, pm_capability_word_pkg::word_e0, 0); cmp(q, 32'h0000_0000);
      $display("reset done");
   endtask : t_reset
   task t_host;
      @(posedge core_clk) host_req <= '{1'b1, 1'b0, 36'h1_0000_0000};
      @(posedge core_clk) host_req <= '{1'b1, 1'b1, 36'h0_ffff_ffff};
      @(negedge core_clk) cmp({31'h0, host_rsp.claim}, 32'h0000_0001);
      cmp(host_rsp.rdata, 32'h0000_0000);
      cmp({31'h0, host_rsp.done}, 32'h0000_0001);
      cmp({31'h0, wake_out}, 32'h0000_0000);
      @(posedge core_clk) host_req <= '0;
      @(negedge core_clk) cmp({31'h0, host_rsp.claim}, 32'h0000_0000);
      $display("host done");
   endtask : t_host
   initial begin
      repeat (12) @(posedge core_clk);
      reset <= 1'b0;
      t_caps;
      t_ctrl;
      t_freeze;
      t_reset;
      t_host;
      give_verdict;
   end
   initial begin
      #20000;
      bad_count++;
      give_verdict;
   end
endmodule : graphics_power_mgmt_capability_test
bind graphics_power_mgmt_capability pm_capability_word_props pm_capability_word_props_inst (.core_clk(core_clk),
   .reset(reset), .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .host_req(host_req), .host_rsp(host_rsp), .wake_out(wake_out), .sleep_level(sleep_level));
